// >>> common/bldmc_pkg.sv
// constants and carrier types for the backlight dimming mode control
// assumes a single 100 MHz clock and a synchronous active-low reset
package bldmc_pkg;

    // register pointer values on the serial bus
    localparam logic [7:0] CFG_OFFSET = 8'h00;
    localparam logic [7:0] BRIGHT_LO_OFFSET = 8'h03;
    localparam logic [7:0] BRIGHT_HI_OFFSET = 8'h04;
    localparam logic [7:0] ID_OFFSET = 8'h06;

    // values after reset
    localparam logic [3:0] CHAN_EN_RESET = 4'hf;
    localparam logic CFG_SPARE_RESET = 1'b0;
    localparam logic CFG_SRC_RESET = 1'b0;
    localparam logic [1:0] CFG_MODE_RESET = 2'h0;
    localparam logic [1:0] BRIGHT_LO_RESET = 2'h3;
    localparam logic [7:0] BRIGHT_HI_RESET = 8'h7f;

    // dimming modes
    localparam logic [1:0] MODE_PWM = 2'h0;
    localparam logic [1:0] MODE_ANALOG = 2'h1;
    localparam logic [1:0] MODE_MIX25 = 2'h2;
    localparam logic [1:0] MODE_MIX50 = 2'h3;

    // duty thresholds on the 10-bit scale, and full scale
    localparam logic [9:0] MIX25_THRESH = 10'h100;
    localparam logic [9:0] MIX50_THRESH = 10'h200;
    localparam logic [9:0] FULL_SCALE = 10'h3ff;

    // internal pwm: fractional accumulator, 1024 phase steps per period
    localparam int CLOCK_KHZ = 100000;
    localparam int INT_PWM_KHZ = 23;
    localparam int DUTY_STEPS = 1024;
    localparam logic [17:0] PWM_ACC_STEP = 18'(INT_PWM_KHZ * DUTY_STEPS);
    localparam logic [17:0] PWM_ACC_MOD = 18'(CLOCK_KHZ);

    // external duty measurement: 10 MHz sampling, 1023-sample window;
    // a window near 0.1 ms keeps the analog level close to the input
    localparam int SAMPLE_KHZ = 10000;
    localparam logic [6:0] SAMPLE_DIV = 7'(CLOCK_KHZ / SAMPLE_KHZ);
    localparam logic [9:0] MEAS_WINDOW = 10'h3ff;

    // serial bus slave address (7 bit)
    localparam logic [6:0] DEV_ADDR = 7'h2c;

    typedef struct packed {
        logic [3:0] chanEn;
        logic spare;
        logic regSource;
        logic [1:0] mode;
    } bldmc_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } bldmc_wr_t;

    typedef enum logic [2:0] {
        SL_IDLE,
        SL_ADDR,
        SL_REG,
        SL_WDATA,
        SL_RDATA,
        SL_ACK,
        SL_MACK
    } bldmc_sl_state_t;

endpackage : bldmc_pkg

// >>> logic/bldmc_dimming_control.sv
// dimming mode control: config and brightness registers, duty measurement,
// internal 23 kHz pwm and pwm/analog/mixed selection for four channels
// assumes pins synchronous to the 100 MHz clock, external pull-up on sda
`timescale 1ns/1ns
module bldmc_dimming_control
#(
    // value is arbitrary, not tied to any maker
    parameter logic [7:0] VENDOR_ID = 8'h5a
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // serial register bus
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // external dimming input
    input wire logic pwmIn,
    // current source controls
    output logic [3:0] channelCurrentEnables,
    output logic [9:0] stringCurrent,
    output logic analogActive
);
    bldmc_pkg::bldmc_cfg_t cfg_q;
    bldmc_pkg::bldmc_wr_t wr;
    logic [1:0] brightnessLowBits_q;
    logic [7:0] brightnessHighBits_q;
    logic [7:0] rdAddr;
    logic [7:0] rdData;
    logic [6:0] sampleCnt_q;
    logic [9:0] winCnt_q;
    logic [9:0] highCnt_q;
    logic [9:0] measDuty_q;
    logic [17:0] acc_q;
    logic [9:0] phase_q;
    logic [3:0] chanOn_q;
    logic [9:0] amplitude_q;
    logic analog_q;
    logic sdaOut_q;

    bldmc_i2c_slave u_slave
    (
        .clock(clock),
        .rst_b(rst_b),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sdaOe(sdaOe),
        .wr(wr),
        .rdAddr(rdAddr),
        .rdData(rdData)
    );

    // register decode
    wire wrCfg = wr.valid & (wr.addr == bldmc_pkg::CFG_OFFSET);
    wire wrLo = wr.valid & (wr.addr == bldmc_pkg::BRIGHT_LO_OFFSET);
    wire wrHi = wr.valid & (wr.addr == bldmc_pkg::BRIGHT_HI_OFFSET);
    // fault bits of the low register are outside this block and read zero
    assign rdData =
        (rdAddr == bldmc_pkg::CFG_OFFSET) ? cfg_q :
        (rdAddr == bldmc_pkg::BRIGHT_LO_OFFSET) ?
            {6'h00, brightnessLowBits_q} :
        (rdAddr == bldmc_pkg::BRIGHT_HI_OFFSET) ? brightnessHighBits_q :
        (rdAddr == bldmc_pkg::ID_OFFSET) ? VENDOR_ID : 8'h00;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            cfg_q <= {bldmc_pkg::CHAN_EN_RESET, bldmc_pkg::CFG_SPARE_RESET,
                      bldmc_pkg::CFG_SRC_RESET,
                      bldmc_pkg::CFG_MODE_RESET};
            brightnessLowBits_q <= bldmc_pkg::BRIGHT_LO_RESET;
            brightnessHighBits_q <= bldmc_pkg::BRIGHT_HI_RESET;
        end
        else
        begin
            if (wrCfg)
                cfg_q <= wr.data;
            if (wrLo)
                brightnessLowBits_q <= wr.data[1:0];
            if (wrHi)
                brightnessHighBits_q <= wr.data;
        end
    end

    // brightness and the duty that steers the mode decision
    wire [9:0] brightness = {brightnessHighBits_q,
                             brightnessLowBits_q};
    wire [9:0] dimmingDuty = cfg_q.regSource ? brightness
                                             : measDuty_q;

    // external duty: count high samples over a fixed window, 1023 = 100%
    wire sampleTick = sampleCnt_q == bldmc_pkg::SAMPLE_DIV - 7'h01;
    wire winEnd = winCnt_q == bldmc_pkg::MEAS_WINDOW - 10'h001;
    wire [9:0] highNext = highCnt_q + {9'h000, pwmIn};

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            sampleCnt_q <= 7'h00;
            winCnt_q <= 10'h000;
            highCnt_q <= 10'h000;
            measDuty_q <= 10'h000;
        end
        else
        begin
            sampleCnt_q <= sampleTick ? 7'h00 : sampleCnt_q + 7'h01;
            if (sampleTick)
            begin
                winCnt_q <= winEnd ? 10'h000 : winCnt_q + 10'h001;
                highCnt_q <= winEnd ? 10'h000 : highNext;
                if (winEnd)
                    measDuty_q <= highNext;
            end
        end
    end

    // internal pwm; fractional stepping keeps the mean rate exact
    wire [17:0] accSum = acc_q + bldmc_pkg::PWM_ACC_STEP;
    wire phaseStep = accSum >= bldmc_pkg::PWM_ACC_MOD;
    // 1023 is the top code, so full brightness leaves one dark step
    wire intPwmOn = phase_q < brightness;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            acc_q <= 18'h00000;
            phase_q <= 10'h000;
        end
        else
        begin
            acc_q <= phaseStep ? accSum - bldmc_pkg::PWM_ACC_MOD : accSum;
            if (phaseStep)
                phase_q <= phase_q + 10'h001;
        end
    end

    // mode selection
    wire isPwm = cfg_q.mode == bldmc_pkg::MODE_PWM;
    wire isAnalog = cfg_q.mode == bldmc_pkg::MODE_ANALOG;
    wire isMix25 = cfg_q.mode == bldmc_pkg::MODE_MIX25;
    wire isMix50 = cfg_q.mode == bldmc_pkg::MODE_MIX50;
    wire overQuarter = dimmingDuty > bldmc_pkg::MIX25_THRESH;
    wire overHalf = dimmingDuty > bldmc_pkg::MIX50_THRESH;
    wire useAnalog = isAnalog | (isMix25 & overQuarter)
                     | (isMix50 & overHalf);
    // the pin is followed directly so the output duty tracks it exactly
    wire pwmSignal = cfg_q.regSource ? intPwmOn : pwmIn;
    wire [3:0] chanOnNext = cfg_q.chanEn
                            & {4{useAnalog | pwmSignal}};

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            chanOn_q <= 4'h0;
            amplitude_q <= bldmc_pkg::FULL_SCALE;
            analog_q <= 1'b0;
            sdaOut_q <= 1'b0;
        end
        else
        begin
            chanOn_q <= chanOnNext;
            amplitude_q <= useAnalog ? dimmingDuty
                                     : bldmc_pkg::FULL_SCALE;
            analog_q <= useAnalog;
        end
    end

    assign sdaOut = sdaOut_q;
    assign channelCurrentEnables = chanOn_q;
    assign stringCurrent = amplitude_q;
    assign analogActive = analog_q;

    a_chan4_gate: assert property (@(posedge clock)
        disable iff (!rst_b)
        chanOn_q[3] |-> $past(cfg_q.chanEn[3]))
        else $error("channel four on while disabled");
    a_src_reset: assert property (@(posedge clock)
        disable iff (!rst_b)
        $rose(rst_b) |-> !cfg_q.regSource && dimmingDuty == measDuty_q)
        else $error("source not external after reset");
    a_mode_reset: assert property (@(posedge clock)
        disable iff (!rst_b)
        $rose(rst_b) |-> cfg_q.mode == bldmc_pkg::MODE_PWM)
        else $error("mode not pwm after reset");
    a_ext_follow: assert property (@(posedge clock)
        disable iff (!rst_b)
        (isPwm && !cfg_q.regSource) |=>
        chanOn_q == $past(cfg_q.chanEn & {4{pwmIn}}) && !analog_q)
        else $error("channels do not follow pwm pin");
    a_int_pwm: assert property (@(posedge clock)
        disable iff (!rst_b)
        (isPwm && cfg_q.regSource) |=>
        chanOn_q == $past(cfg_q.chanEn & {4{intPwmOn}})
        && amplitude_q == bldmc_pkg::FULL_SCALE)
        else $error("internal pwm not driving channels");
    a_analog_ext: assert property (@(posedge clock)
        disable iff (!rst_b)
        (isAnalog && !cfg_q.regSource) |=>
        analog_q && amplitude_q == $past(measDuty_q)
        && chanOn_q == $past(cfg_q.chanEn))
        else $error("analog amplitude not measured duty");
    a_analog_reg: assert property (@(posedge clock)
        disable iff (!rst_b)
        (isAnalog && cfg_q.regSource) |=> amplitude_q == $past(brightness))
        else $error("analog amplitude not brightness");
    a_mix_quarter: assert property (@(posedge clock)
        disable iff (!rst_b)
        isMix25 |=> analog_q == $past(dimmingDuty > 10'h100))
        else $error("quarter threshold wrong");
    a_mix_half: assert property (@(posedge clock)
        disable iff (!rst_b)
        (isMix50 && dimmingDuty > 10'h200) |=> analog_q)
        else $error("half threshold analog missing");
    a_mix_fallback: assert property (@(posedge clock)
        disable iff (!rst_b)
        (isMix50 && dimmingDuty <= 10'h200) |=>
        !analog_q && amplitude_q == bldmc_pkg::FULL_SCALE)
        else $error("half threshold pwm fallback wrong");
    a_bright_write: assert property (@(posedge clock)
        disable iff (!rst_b)
        wrHi |=> brightnessHighBits_q == $past(wr.data)
        && brightness[1:0] == $past(brightnessLowBits_q))
        else $error("brightness high write lost");
    a_en_reset: assert property (@(posedge clock)
        disable iff (!rst_b)
        $rose(rst_b) |-> cfg_q.chanEn == 4'hf)
        else $error("channels not enabled after reset");

endmodule : bldmc_dimming_control

// >>> logic/bldmc_i2c_slave.sv
// serial register bus slave: address, pointer byte, data with auto-increment
// assumes scl/sda are already synchronous to clock; sdaOe high pulls sda low
`timescale 1ns/1ns
module bldmc_i2c_slave
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOe,
    // register side
    output bldmc_pkg::bldmc_wr_t wr,
    output logic [7:0] rdAddr,
    input wire logic [7:0] rdData
);
    bldmc_pkg::bldmc_sl_state_t state_q;
    bldmc_pkg::bldmc_sl_state_t after_q;
    bldmc_pkg::bldmc_wr_t wr_q;
    logic sclPrev_q;
    logic sdaPrev_q;
    logic sdaOe_q;
    logic ackDrv_q;
    logic nack_q;
    logic [2:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;

    wire sclRise = sclIn & ~sclPrev_q;
    wire sclFall = ~sclIn & sclPrev_q;
    wire startSeen = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
    wire stopSeen = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;
    wire [7:0] shiftIn = {shift_q[6:0], sdaIn};
    wire byteDone = sclRise & (bitCnt_q == 3'h7);
    wire addrHit = shiftIn[7:1] == bldmc_pkg::DEV_ADDR;

    assign sdaOe = sdaOe_q;
    assign wr = wr_q;
    assign rdAddr = ptr_q;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state_q <= bldmc_pkg::SL_IDLE;
            after_q <= bldmc_pkg::SL_IDLE;
            wr_q <= '0;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            sdaOe_q <= 1'b0;
            ackDrv_q <= 1'b0;
            nack_q <= 1'b0;
            bitCnt_q <= 3'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
        end
        else
        begin
            sclPrev_q <= sclIn;
            sdaPrev_q <= sdaIn;
            wr_q.valid <= 1'b0;
            // start and stop override any byte in flight
            if (startSeen)
            begin
                state_q <= bldmc_pkg::SL_ADDR;
                bitCnt_q <= 3'h0;
                sdaOe_q <= 1'b0;
            end
            else if (stopSeen)
            begin
                state_q <= bldmc_pkg::SL_IDLE;
                sdaOe_q <= 1'b0;
            end
            else
            begin
                case (state_q)
                    bldmc_pkg::SL_ADDR, bldmc_pkg::SL_REG,
                    bldmc_pkg::SL_WDATA:
                    begin
                        if (sclRise)
                        begin
                            shift_q <= shiftIn;
                            bitCnt_q <= bitCnt_q + 3'h1;
                        end
                        if (byteDone)
                        begin
                            state_q <= bldmc_pkg::SL_ACK;
                            ackDrv_q <= 1'b0;
                            after_q <= bldmc_pkg::SL_WDATA;
                            if (state_q == bldmc_pkg::SL_ADDR)
                            begin
                                if (!addrHit)
                                    state_q <= bldmc_pkg::SL_IDLE;
                                after_q <= shiftIn[0] ? bldmc_pkg::SL_RDATA
                                                      : bldmc_pkg::SL_REG;
                            end
                            else if (state_q == bldmc_pkg::SL_REG)
                                ptr_q <= shiftIn;
                            else
                            begin
                                wr_q <= {1'b1, ptr_q, shiftIn};
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                    bldmc_pkg::SL_ACK:
                    begin
                        if (sclFall && !ackDrv_q)
                        begin
                            ackDrv_q <= 1'b1;
                            sdaOe_q <= 1'b1;
                        end
                        else if (sclFall)
                        begin
                            state_q <= after_q;
                            bitCnt_q <= 3'h0;
                            shift_q <= rdData;
                            sdaOe_q <= (after_q == bldmc_pkg::SL_RDATA)
                                       & ~rdData[7];
                        end
                    end
                    bldmc_pkg::SL_RDATA:
                    begin
                        if (sclFall)
                        begin
                            bitCnt_q <= bitCnt_q + 3'h1;
                            shift_q <= {shift_q[6:0], 1'b0};
                            sdaOe_q <= (bitCnt_q != 3'h7) & ~shift_q[6];
                            if (bitCnt_q == 3'h7)
                            begin
                                state_q <= bldmc_pkg::SL_MACK;
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                    bldmc_pkg::SL_MACK:
                    begin
                        if (sclRise)
                            nack_q <= sdaIn;
                        else if (sclFall && nack_q)
                            state_q <= bldmc_pkg::SL_IDLE;
                        else if (sclFall)
                        begin
                            state_q <= bldmc_pkg::SL_RDATA;
                            bitCnt_q <= 3'h0;
                            shift_q <= rdData;
                            sdaOe_q <= ~rdData[7];
                        end
                    end
                    default:
                        state_q <= bldmc_pkg::SL_IDLE;
                endcase
            end
        end
    end

endmodule : bldmc_i2c_slave

// >>> testbench/bldmc_host_model.sv
// serial bus host model: drives scl and an open-drain sda
// assumes a pull-up on sda, device pins sampled on the bench clock
`timescale 1ns/1ns
module bldmc_host_model
(
    // clock
    input wire logic clock,
    // bus pins
    input wire logic devPull,
    output logic sclIn,
    output logic sdaIn
);
    logic hostLow;
    logic nak;
    logic ackOk;
    logic [7:0] rx;

    // pull-up: a released line reads high
    assign sdaIn = ~(hostLow | devPull);

    initial
    begin
        sclIn = 1'b1;
        hostLow = 1'b0;
        ackOk = 1'b1;
    end

    // three clocks a phase, above the two-clock minimum
    task tick;
        repeat (3) @(posedge clock);
    endtask : tick

    // drive 0 pulls low; drive 1 releases so the device may answer
    task bit_io(input logic drv, output logic b);
        hostLow <= ~drv;
        tick;
        sclIn <= 1'b1;
        tick;
        b = sdaIn;
        sclIn <= 1'b0;
        tick;
    endtask : bit_io

    task start;
        hostLow <= 1'b0;
        tick;
        sclIn <= 1'b1;
        tick;
        hostLow <= 1'b1;
        tick;
        sclIn <= 1'b0;
        tick;
    endtask : start

    task stop;
        hostLow <= 1'b1;
        tick;
        sclIn <= 1'b1;
        tick;
        hostLow <= 1'b0;
        tick;
    endtask : stop

    // eight bits msb first, then the acknowledge bit
    task xfer(input logic [7:0] v, input logic a, input logic chk);
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], rx[i]);
        bit_io(a, nak);
        if (chk && nak)
            ackOk = 1'b0;
    endtask : xfer

    task wr(input logic [7:0] ptr, lo, hi, input logic two);
        ackOk = 1'b1;
        start;
        xfer({bldmc_pkg::DEV_ADDR, 1'b0}, 1'b1, 1'b1);
        xfer(ptr, 1'b1, 1'b1);
        xfer(lo, 1'b1, 1'b1);
        if (two)
            xfer(hi, 1'b1, 1'b1);
        stop;
    endtask : wr

    // two bytes from ptr on; host acks the first, nacks the second
    task rd(input logic [7:0] ptr, output logic [7:0] d0, d1);
        ackOk = 1'b1;
        start;
        xfer({bldmc_pkg::DEV_ADDR, 1'b0}, 1'b1, 1'b1);
        xfer(ptr, 1'b1, 1'b1);
        start;
        xfer({bldmc_pkg::DEV_ADDR, 1'b1}, 1'b1, 1'b1);
        xfer(8'hff, 1'b0, 1'b0);
        d0 = rx;
        xfer(8'hff, 1'b1, 1'b0);
        d1 = rx;
        stop;
    endtask : rd

    // address byte alone; a foreign address must draw no acknowledge
    task probe(input logic [6:0] a);
        ackOk = 1'b1;
        start;
        xfer({a, 1'b0}, 1'b1, 1'b1);
        stop;
    endtask : probe
endmodule : bldmc_host_model

// >>> testbench/tb_top.sv
// self-checking bench for the dimming mode control
// assumes the host model on the serial bus; pwm source driven here
`timescale 1ns/1ns
module tb_top;
    // value is arbitrary, not tied to any maker
    localparam logic [7:0] TB_ID = 8'h3c;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic pwmIn = 1'b0;
    logic sclIn;
    logic sdaIn;
    logic sdaOut;
    logic sdaOe;
    logic [3:0] chEn;
    logic [9:0] cur;
    logic an;
    logic [7:0] d0;
    logic [7:0] d1;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    int modeM = 0;
    int srcM = 0;
    int enM = 15;
    int brightM = 511;
    int b;
    // reference duty meter, built from the sampling rate and window alone
    int smpM = 0;
    int winM = 0;
    int hiM = 0;
    int measM = 0;
    int measLagM = 0;

    bldmc_dimming_control #(.VENDOR_ID(TB_ID)) DUT
    (
        .clock(clock), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .pwmIn(pwmIn),
        .channelCurrentEnables(chEn), .stringCurrent(cur),
        .analogActive(an)
    );

    bldmc_host_model host
    (
        .clock(clock), .devPull(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn)
    );

    initial
    begin
        forever #5 clock = ~clock;
    end

    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    // expected run is near 50k cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            error_cnt++;
            $display("BAD timeout expected 0 seen 1");
            finish_test;
        end
    end

    // one pwm sample per divider period, 1023 samples a window; the lagged
    // copy is what the outputs show, as they follow one clock later
    always @(posedge clock)
    begin
        measLagM = measM;
        if (!rst_b)
        begin
            smpM = 0;
            winM = 0;
            hiM = 0;
            measM = 0;
        end
        else
        begin
            smpM++;
            if (smpM == int'(bldmc_pkg::SAMPLE_DIV))
            begin
                smpM = 0;
                hiM += int'(pwmIn);
                winM++;
                if (winM == int'(bldmc_pkg::MEAS_WINDOW))
                begin
                    winM = 0;
                    measM = hiM;
                    hiM = 0;
                end
            end
        end
    end

    task check(input string nm, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task set_cfg(input logic [7:0] v);
        host.wr(bldmc_pkg::CFG_OFFSET, v, 8'h00, 1'b0);
        repeat (4) @(posedge clock);
        enM = v[7:4];
        srcM = v[2];
        modeM = v[1:0];
        host.rd(bldmc_pkg::CFG_OFFSET, d0, d1);
        check("cfgRead", 16'(d0), 16'(v));
    endtask : set_cfg

    // low bits then high bits, pointer auto-increments
    task set_bright(input logic [9:0] v);
        host.wr(bldmc_pkg::BRIGHT_LO_OFFSET, {6'h00, v[1:0]}, v[9:2], 1'b1);
        repeat (4) @(posedge clock);
        brightM = v;
        host.rd(bldmc_pkg::BRIGHT_LO_OFFSET, d0, d1);
        check("brightRead", {d0[7:2], d1, d0[1:0]}, 16'(v));
    endtask : set_bright

    // random pwm input; outputs follow inputs one clock later
    task run_chk(input int n);
        logic lp;
        logic ean;
        int duty;
        repeat (n)
        begin
            @(posedge clock);
            lp = pwmIn;
            pwmIn <= 1'($urandom);
            @(negedge clock);
            duty = srcM ? brightM : measLagM;
            ean = modeM == 1 || (modeM == 2 && duty > 256)
                || (modeM == 3 && duty > 512);
            check("analogActive", 16'(an), 16'(ean));
            check("stringCurrent", 16'(cur),
                ean ? 16'(duty) : 16'h3ff);
            if (ean)
                check("chanAnalog", 16'(chEn), 16'(enM));
            else if (srcM == 0)
                check("chanPwm", 16'(chEn),
                    lp ? 16'(enM) : 16'h0);
            else
                check("chanMask", 16'(chEn & ~4'(enM)), 16'h0);
        end
    endtask : run_chk

    // on-time and edge count of channel one over n cycles
    task meas(input int n, input int v);
        int on;
        int rises;
        int ex;
        int diff;
        logic prev;
        on = 0;
        rises = 0;
        prev = 1'b1;
        repeat (n)
        begin
            @(negedge clock);
            if (chEn[0] === 1'b1 && prev !== 1'b1)
                rises++;
            if (chEn[0] === 1'b1)
                on++;
            prev = chEn[0];
        end
        ex = v == 0 ? 0 : n * 23 / 100000;
        diff = on * 1024 - v * n;
        diff = diff < 0 ? -diff : diff;
        check("pwmOnTime", 16'(diff <= (v == 0 ? 0 : n * 20)),
            16'h1);
        check("pwmRate", 16'(rises >= ex - 1 && rises <= ex + 1),
            16'h1);
    endtask : meas

    initial
    begin
        void'($urandom(78));
        repeat (9) @(posedge clock);
        @(negedge clock);
        check("rstChan", 16'(chEn), 16'h0);
        check("rstCur", 16'(cur), 16'h3ff);
        check("rstAnalog", 16'(an), 16'h0);
        @(posedge clock);
        rst_b <= 1'b1;
        host.rd(bldmc_pkg::CFG_OFFSET, d0, d1);
        check("cfgReset", 16'(d0), 16'hf0);
        check("reg01", 16'(d1), 16'h0);
        host.rd(bldmc_pkg::BRIGHT_LO_OFFSET, d0, d1);
        check("brightReset", {d0[7:2], d1, d0[1:0]}, 16'h1ff);
        // id register is read-only; unmapped pointer 05 reads zero
        host.wr(bldmc_pkg::ID_OFFSET, 8'ha5, 8'h5a, 1'b1);
        host.rd(8'h05, d0, d1);
        check("reg05", 16'(d0), 16'h0);
        check("idRead", 16'(d1), 16'(TB_ID));
        check("ackSeen", 16'(host.ackOk), 16'h1);
        // a foreign address draws no acknowledge
        host.probe(bldmc_pkg::DEV_ADDR ^ 7'h01);
        check("nakForeign", 16'(host.ackOk), 16'h0);
        run_chk(200);
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 2; s++)
            begin
                set_cfg({4'($urandom_range(0, 15)), 1'b0, 1'(s), 2'(m)});
                if (s == 1)
                begin
                    b = m == 2 ? 256 : m == 3 ? 512 : $urandom_range(0, 1022);
                    set_bright(10'(b));
                    run_chk(60);
                    set_bright(10'(b + 1));
                end
                run_chk(100);
            end
        // external analog across a window end: amplitude tracks the meter
        set_cfg(8'hf1);
        run_chk(10400);
        set_cfg(8'hf4);
        set_bright(10'($urandom_range(100, 900)));
        meas(21740, brightM);
        set_bright(10'h000);
        meas(1000, 0);
        check("sdaOut", 16'(sdaOut), 16'h0);
        finish_test;
    end
endmodule : tb_top
